// ---- logic/clk_gate_pkg.sv ----
// package with register map, field layout and bus carriers for the peripheral clock gating registers
package clk_gate_pkg;

    // bus geometry
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          STRB_W          = DATA_W / 8;

    // register byte offsets
    localparam logic [11:0] HSB_GATE_OFFSET = 12'h000;
    localparam logic [11:0] PB2_GATE_OFFSET = 12'h004;

    // reset value of both registers
    localparam logic [31:0] GATE_RESET      = 32'h0000_0000;

    // high-speed bus gate fields
    localparam int          PORT_F_BIT      = 22;
    localparam int          PORT_D_BIT      = 20;
    localparam int          PORT_C_BIT      = 19;
    localparam int          PORT_B_BIT      = 18;
    localparam int          PORT_A_BIT      = 17;
    localparam int          USB_FS_BIT      = 12;
    localparam int          CHECKSUM_BIT    = 6;
    localparam int          FLASH_KEEP_BIT  = 4;
    localparam int          RAM_KEEP_BIT    = 2;
    localparam int          DMA_BIT         = 0;

    // peripheral bus 2 gate fields
    localparam int          TIMER_G_BIT     = 18;
    localparam int          TIMER_F_BIT     = 17;
    localparam int          TIMER_E_BIT     = 16;
    localparam int          SERIAL_A_BIT    = 14;
    localparam int          SYNC_SER_A_BIT  = 12;
    localparam int          ADV_TIMER_BIT   = 11;
    localparam int          CONVERTER_BIT   = 9;
    localparam int          SYS_CFG_BIT     = 0;

    // implemented bits; every other position is reserved and reads zero
    localparam logic [31:0] HSB_GATE_MASK   = 32'h005e_1055;
    localparam logic [31:0] PB2_GATE_MASK   = 32'h0007_5a01;

    // apb request from the master
    typedef struct packed {
        logic                psel;
        logic                penable;
        logic                pwrite;
        logic [ADDR_W-1:0]   paddr;
        logic [DATA_W-1:0]   pwdata;
        logic [STRB_W-1:0]   pstrb;
    } apb_req_s;

    // apb answer to the master
    typedef struct packed {
        logic                pready;
        logic                pslverr;
        logic [DATA_W-1:0]   prdata;
    } apb_rsp_s;

    // clock run enables towards the peripherals
    typedef struct packed {
        logic                port_f_clk_on;
        logic                port_d_clk_on;
        logic                port_c_clk_on;
        logic                port_b_clk_on;
        logic                port_a_clk_on;
        logic                usb_fullspeed_clk_on;
        logic                checksum_unit_clk_on;
        logic                dma_ctrl_clk_on;
        logic                timer_g_clk_on;
        logic                timer_f_clk_on;
        logic                timer_e_clk_on;
        logic                serial_port_a_clk_on;
        logic                sync_serial_a_clk_on;
        logic                advanced_timer_clk_on;
        logic                converter_clk_on;
        logic                sys_config_clk_on;
        logic                flash_clk_run;
        logic                ram_clk_run;
    } gate_out_s;

endpackage : clk_gate_pkg

// ---- logic/gate_word.sv ----
// one clock gating register word with byte-lane writes and reserved bits held at zero
module gate_word #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] WMASK = 32'hffff_ffff,
    parameter logic [31:0] RSTV  = 32'h0000_0000
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // write port
    input  wire logic             we,
    input  wire logic [WIDTH/8-1:0] strb,
    input  wire logic [WIDTH-1:0] wdata,
    // stored value
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] lane_mask;
    logic [WIDTH-1:0] next_q;

    // elaboration check on the word width
    if (WIDTH != 32) begin : g_bad_width
        $error("gate_word supports a 32-bit word only");
    end

    // expand byte strobes to a bit mask
    genvar g;
    for (g = 0; g < WIDTH / 8; g++) begin : g_lane
        assign lane_mask[g*8 +: 8] = {8{strb[g]}};
    end

    // only addressed lanes and implemented bits change
    assign next_q = (q & ~(lane_mask & WMASK)) | (wdata & lane_mask & WMASK);

    // storage, cleared at reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= RSTV;
        end else if (we) begin
            q <= next_q;
        end
    end

endmodule : gate_word

// ---- logic/peripheral_clock_gate_regs.sv ----
// apb register block that holds the peripheral clock gating words and drives the clock enables
//
// Functional notes
// - both registers take 32, 16 and 8 bit writes, and a narrow write alters only its byte lanes.
// - a register access is held in wait states while a transfer on the second peripheral bus is unfinished.
// - the flash keep bit keeps the flash clock running in sleep and deep sleep, and resets to zero.
// - the ram keep bit keeps the sram clock running in sleep and deep sleep, and resets to zero.
// - reserved bits read zero and ignore writes, and software writes them back at zero.
//
// Chosen here: the placing of the registers and the APB slave port.
module peripheral_clock_gate_regs (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // apb slave
    input  wire clk_gate_pkg::apb_req_s apb_req,
    output clk_gate_pkg::apb_rsp_s      apb_rsp,
    // system state
    input  wire logic                  bus2_xfer_busy,
    input  wire logic                  low_power_mode,
    // clock enables
    output clk_gate_pkg::gate_out_s     gate_out
);
    import clk_gate_pkg::*;

    // stored words
    logic [DATA_W-1:0] hsb_gate;
    logic [DATA_W-1:0] pb2_gate;

    // decode wires
    logic              hit_hsb;
    logic              hit_pb2;
    logic              hit_any;
    logic              access_phase;
    logic              xfer_done;
    logic              wr_done;
    logic              we_hsb;
    logic              we_pb2;
    logic              next_pready;
    logic              next_pslverr;
    logic [DATA_W-1:0] next_prdata;
    logic [DATA_W-1:0] rd_mux;
    gate_out_s         next_gate_out;

    // word address decode, low two address bits ignored
    assign hit_hsb      = (apb_req.paddr[ADDR_W-1:2] == HSB_GATE_OFFSET[ADDR_W-1:2]);
    assign hit_pb2      = (apb_req.paddr[ADDR_W-1:2] == PB2_GATE_OFFSET[ADDR_W-1:2]);
    assign hit_any      = hit_hsb | hit_pb2;

    // access phase tracking
    assign access_phase = apb_req.psel & apb_req.penable;
    assign xfer_done    = access_phase & apb_rsp.pready;
    assign wr_done      = xfer_done & apb_req.pwrite & ~apb_rsp.pslverr;

    // write strobes, taken at the completing edge only
    assign we_hsb       = wr_done & hit_hsb;
    assign we_pb2       = wr_done & hit_pb2;

    // ready waits while the second peripheral bus is busy
    assign next_pready  = access_phase & ~apb_rsp.pready & ~bus2_xfer_busy;
    assign next_pslverr = next_pready & ~hit_any;

    // read mux; unmapped offsets and reserved bits return zero
    assign rd_mux       = hit_hsb ? (hsb_gate & HSB_GATE_MASK) :
                          hit_pb2 ? (pb2_gate & PB2_GATE_MASK) : '0;
    assign next_prdata  = (next_pready & ~apb_req.pwrite) ? rd_mux : '0;

    // high-speed bus gate word
    gate_word #(
        .WIDTH (DATA_W),
        .WMASK (HSB_GATE_MASK),
        .RSTV  (GATE_RESET)
    ) u_hsb_gate (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (we_hsb),
        .strb  (apb_req.pstrb),
        .wdata (apb_req.pwdata),
        .q     (hsb_gate)
    );

    // peripheral bus 2 gate word
    gate_word #(
        .WIDTH (DATA_W),
        .WMASK (PB2_GATE_MASK),
        .RSTV  (GATE_RESET)
    ) u_pb2_gate (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (we_pb2),
        .strb  (apb_req.pstrb),
        .wdata (apb_req.pwdata),
        .q     (pb2_gate)
    );

    // peripheral enables follow their bits
    assign next_gate_out.port_f_clk_on         = hsb_gate[PORT_F_BIT];
    assign next_gate_out.port_d_clk_on         = hsb_gate[PORT_D_BIT];
    assign next_gate_out.port_c_clk_on         = hsb_gate[PORT_C_BIT];
    assign next_gate_out.port_b_clk_on         = hsb_gate[PORT_B_BIT];
    assign next_gate_out.port_a_clk_on         = hsb_gate[PORT_A_BIT];
    assign next_gate_out.usb_fullspeed_clk_on  = hsb_gate[USB_FS_BIT];
    assign next_gate_out.checksum_unit_clk_on  = hsb_gate[CHECKSUM_BIT];
    assign next_gate_out.dma_ctrl_clk_on       = hsb_gate[DMA_BIT];
    assign next_gate_out.timer_g_clk_on        = pb2_gate[TIMER_G_BIT];
    assign next_gate_out.timer_f_clk_on        = pb2_gate[TIMER_F_BIT];
    assign next_gate_out.timer_e_clk_on        = pb2_gate[TIMER_E_BIT];
    assign next_gate_out.serial_port_a_clk_on  = pb2_gate[SERIAL_A_BIT];
    assign next_gate_out.sync_serial_a_clk_on  = pb2_gate[SYNC_SER_A_BIT];
    assign next_gate_out.advanced_timer_clk_on = pb2_gate[ADV_TIMER_BIT];
    assign next_gate_out.converter_clk_on      = pb2_gate[CONVERTER_BIT];
    assign next_gate_out.sys_config_clk_on     = pb2_gate[SYS_CFG_BIT];

    // memory clocks stop in low power unless kept alive
    assign next_gate_out.flash_clk_run = ~low_power_mode | hsb_gate[FLASH_KEEP_BIT];
    assign next_gate_out.ram_clk_run   = ~low_power_mode | hsb_gate[RAM_KEEP_BIT];

    // bus answer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready  <= next_pready;
            apb_rsp.pslverr <= next_pslverr;
            apb_rsp.prdata  <= next_prdata;
        end
    end

    // enable output registers; memory clocks run through reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_out               <= '0;
            gate_out.flash_clk_run <= 1'b1;
            gate_out.ram_clk_run   <= 1'b1;
        end else begin
            gate_out <= next_gate_out;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------

    // write transfer that completes on the high-speed gate word
    sequence s_hsb_write;
        apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && hit_hsb;
    endsequence

    // write transfer that completes on the bus 2 gate word
    sequence s_pb2_write;
        apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && hit_pb2;
    endsequence

    // read transfer that completes on any offset
    sequence s_read_done;
        apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite;
    endsequence

    // write transfer that completes on an unmapped offset
    sequence s_err_write;
        apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && !hit_any;
    endsequence

    // narrow write leaves unaddressed lanes unchanged
    a_lane_keep_hsb: assert property (@(posedge clk) disable iff (!rst_n)
        s_hsb_write |=> ((hsb_gate ^ $past(hsb_gate)) & ~{{8{$past(apb_req.pstrb[3])}},
            {8{$past(apb_req.pstrb[2])}}, {8{$past(apb_req.pstrb[1])}}, {8{$past(apb_req.pstrb[0])}}}) == '0)
        else $error("unaddressed byte lane changed");

    // same lane guard on the bus 2 gate word
    a_lane_keep_pb2: assert property (@(posedge clk) disable iff (!rst_n)
        s_pb2_write |=> ((pb2_gate ^ $past(pb2_gate)) & ~{{8{$past(apb_req.pstrb[3])}},
            {8{$past(apb_req.pstrb[2])}}, {8{$past(apb_req.pstrb[1])}}, {8{$past(apb_req.pstrb[0])}}}) == '0)
        else $error("unaddressed byte lane changed on bus 2 word");

    // full word write on the bus 2 gate word takes write data on implemented bits
    a_lane_take_pb2: assert property (@(posedge clk) disable iff (!rst_n)
        (s_pb2_write and (apb_req.pstrb == 4'hf)) |=>
            pb2_gate == ($past(apb_req.pwdata) & PB2_GATE_MASK))
        else $error("full word write not stored");

    // full word write on the high-speed gate word
    a_lane_take_hsb: assert property (@(posedge clk) disable iff (!rst_n)
        (s_hsb_write and (apb_req.pstrb == 4'hf)) |=>
            hsb_gate == ($past(apb_req.pwdata) & HSB_GATE_MASK))
        else $error("full word write not stored on high-speed word");

    // no ready while the second bus is busy
    a_wait_busy: assert property (@(posedge clk) disable iff (!rst_n)
        bus2_xfer_busy |=> !apb_rsp.pready)
        else $error("ready given during busy bus 2 transfer");

    // ready follows one cycle after busy ends in an access phase
    a_wait_release: assert property (@(posedge clk) disable iff (!rst_n)
        (access_phase && !apb_rsp.pready && !bus2_xfer_busy) |=> apb_rsp.pready)
        else $error("ready late after bus 2 idle");

    // ready is a one cycle pulse per transfer
    a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held longer than one cycle");

    // answer fields stay low outside a ready cycle
    a_rsp_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !apb_rsp.pready |-> (apb_rsp.prdata == '0) && !apb_rsp.pslverr)
        else $error("read data or error outside ready");

    // flash clock honours keep bit in low power
    a_flash_keep: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 $past(low_power_mode) |-> (gate_out.flash_clk_run == $past(hsb_gate[FLASH_KEEP_BIT])))
        else $error("flash clock wrong in low power");

    // ram clock stops in low power while its keep bit is clear
    a_ram_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (low_power_mode && !hsb_gate[RAM_KEEP_BIT]) |=> !gate_out.ram_clk_run)
        else $error("ram clock runs in low power without keep");

    // flash keep bit clear right after reset
    a_flash_reset: assert property (@(posedge clk)
        $rose(rst_n) |-> !hsb_gate[FLASH_KEEP_BIT])
        else $error("flash keep bit not cleared by reset");

    // ram keep bit clear right after reset
    a_ram_reset: assert property (@(posedge clk)
        $rose(rst_n) |-> !hsb_gate[RAM_KEEP_BIT])
        else $error("ram keep bit not cleared by reset");

    // reserved bits never read back set
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        ((hsb_gate & ~HSB_GATE_MASK) == '0) && ((pb2_gate & ~PB2_GATE_MASK) == '0)
            && (!apb_rsp.pready || apb_rsp.pslverr || apb_req.pwrite ||
                (apb_rsp.prdata & ~(hit_hsb ? HSB_GATE_MASK : PB2_GATE_MASK)) == '0))
        else $error("reserved bit set");

    // unmapped write answers with error and stores nothing
    a_err_write: assert property (@(posedge clk) disable iff (!rst_n)
        s_err_write |-> apb_rsp.pslverr ##1 ($stable(hsb_gate) && $stable(pb2_gate)))
        else $error("unmapped write not refused");

    // completing read returns the stored high-speed word
    a_read_hsb: assert property (@(posedge clk) disable iff (!rst_n)
        (s_read_done and hit_hsb) |-> (apb_rsp.prdata == (hsb_gate & HSB_GATE_MASK)))
        else $error("high-speed word read data wrong");

    // dma and system configuration enables zero right after reset, dma enable then tracks its bit
    a_enable_track: assert property (@(posedge clk)
        $rose(rst_n) |-> (gate_out.dma_ctrl_clk_on == 1'b0) && (gate_out.sys_config_clk_on == 1'b0)
            ##1 (gate_out.dma_ctrl_clk_on == $past(hsb_gate[DMA_BIT])))
        else $error("enable not cleared or not tracking");

    // port f clock follows its bit
    a_port_f_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.port_f_clk_on == $past(hsb_gate[PORT_F_BIT])))
        else $error("port f enable not tracking");

    // port d clock follows its bit
    a_port_d_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.port_d_clk_on == $past(hsb_gate[PORT_D_BIT])))
        else $error("port d enable not tracking");

    // port c clock follows its bit
    a_port_c_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.port_c_clk_on == $past(hsb_gate[PORT_C_BIT])))
        else $error("port c enable not tracking");

    // port b clock follows its bit
    a_port_b_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.port_b_clk_on == $past(hsb_gate[PORT_B_BIT])))
        else $error("port b enable not tracking");

    // port a clock follows its bit
    a_port_a_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.port_a_clk_on == $past(hsb_gate[PORT_A_BIT])))
        else $error("port a enable not tracking");

    // usb clock follows its bit
    a_usb_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.usb_fullspeed_clk_on == $past(hsb_gate[USB_FS_BIT])))
        else $error("usb enable not tracking");

    // checksum unit clock follows its bit
    a_checksum_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.checksum_unit_clk_on == $past(hsb_gate[CHECKSUM_BIT])))
        else $error("checksum enable not tracking");

    // dma clock follows its bit
    a_dma_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.dma_ctrl_clk_on == $past(hsb_gate[DMA_BIT])))
        else $error("dma enable not tracking");

    // timer g clock follows its bit
    a_timer_g_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.timer_g_clk_on == $past(pb2_gate[TIMER_G_BIT])))
        else $error("timer g enable not tracking");

    // timer f clock follows its bit
    a_timer_f_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.timer_f_clk_on == $past(pb2_gate[TIMER_F_BIT])))
        else $error("timer f enable not tracking");

    // timer e clock follows its bit
    a_timer_e_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.timer_e_clk_on == $past(pb2_gate[TIMER_E_BIT])))
        else $error("timer e enable not tracking");

    // serial port clock follows its bit
    a_serial_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.serial_port_a_clk_on == $past(pb2_gate[SERIAL_A_BIT])))
        else $error("serial port enable not tracking");

    // synchronous serial clock follows its bit
    a_sync_ser_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.sync_serial_a_clk_on == $past(pb2_gate[SYNC_SER_A_BIT])))
        else $error("synchronous serial enable not tracking");

    // advanced timer clock follows its bit
    a_adv_timer_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.advanced_timer_clk_on == $past(pb2_gate[ADV_TIMER_BIT])))
        else $error("advanced timer enable not tracking");

    // converter clock follows its bit
    a_converter_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.converter_clk_on == $past(pb2_gate[CONVERTER_BIT])))
        else $error("converter enable not tracking");

    // system configuration clock follows its bit
    a_sys_cfg_track: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (gate_out.sys_config_clk_on == $past(pb2_gate[SYS_CFG_BIT])))
        else $error("system configuration enable not tracking");

endmodule : peripheral_clock_gate_regs

// ---- tb/peripheral_clock_gate_regs_tb.sv ----
// self-checking bench for the peripheral clock gating register block
module peripheral_clock_gate_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_gate_pkg::*;

    logic        clk;
    logic        rst_n;
    apb_req_s    apb_req;
    apb_rsp_s    apb_rsp;
    apb_rsp_s    rsp_q;
    logic        bus2_xfer_busy;
    logic        low_power_mode;
    gate_out_s   gate_out;
    int          n_mismatch;
    int          checked;
    int          cycles;
    int          lat;
    logic [31:0] d;
    logic        e;
    logic [11:0] adr [2];
    logic [31:0] msk [2];

    peripheral_clock_gate_regs i_dut (
        .clk            (clk),
        .rst_n          (rst_n),
        .apb_req        (apb_req),
        .apb_rsp        (apb_rsp),
        .bus2_xfer_busy (bus2_xfer_busy),
        .low_power_mode (low_power_mode),
        .gate_out       (gate_out)
    );

    // free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // answer as it stood before each rising edge
    always @(negedge clk) rsp_q <= apb_rsp;

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            $display("CHECK FAILED timeout expected end seen %0d cycles", cycles);
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : check_word

    // compare enables once the register-to-output lag has passed
    task automatic check_gate(input gate_out_s exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        checked++;
        if (gate_out !== exp) begin
            $display("CHECK FAILED gate_out expected %h seen %h", exp, gate_out);
            n_mismatch++;
        end
    endtask : check_gate

    function automatic gate_out_s exp_gate(input logic [31:0] h, input logic [31:0] p, input logic lpm);
        gate_out_s g;
        g.port_f_clk_on         = h[PORT_F_BIT];
        g.port_d_clk_on         = h[PORT_D_BIT];
        g.port_c_clk_on         = h[PORT_C_BIT];
        g.port_b_clk_on         = h[PORT_B_BIT];
        g.port_a_clk_on         = h[PORT_A_BIT];
        g.usb_fullspeed_clk_on  = h[USB_FS_BIT];
        g.checksum_unit_clk_on  = h[CHECKSUM_BIT];
        g.dma_ctrl_clk_on       = h[DMA_BIT];
        g.timer_g_clk_on        = p[TIMER_G_BIT];
        g.timer_f_clk_on        = p[TIMER_F_BIT];
        g.timer_e_clk_on        = p[TIMER_E_BIT];
        g.serial_port_a_clk_on  = p[SERIAL_A_BIT];
        g.sync_serial_a_clk_on  = p[SYNC_SER_A_BIT];
        g.advanced_timer_clk_on = p[ADV_TIMER_BIT];
        g.converter_clk_on      = p[CONVERTER_BIT];
        g.sys_config_clk_on     = p[SYS_CFG_BIT];
        g.flash_clk_run         = !lpm | h[FLASH_KEEP_BIT];
        g.ram_clk_run           = !lpm | h[RAM_KEEP_BIT];
        return g;
    endfunction : exp_gate

    // one apb transfer; edges counts rising edges from setup to completion
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                            output logic [31:0] rdata, output logic serr, output int edges);
        edges = 1;
        @(posedge clk);
        apb_req.psel    <= 1'b1;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= wd;
        apb_req.pstrb   <= st;
        @(posedge clk);
        edges++;
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            edges++;
        end while (rsp_q.pready !== 1'b1 && edges < 200);
        rdata = rsp_q.prdata;
        serr  = rsp_q.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb_xfer

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st, input logic eerr);
        apb_xfer(1'b1, a, wd, st, d, e, lat);
        check_word("write error", {31'h0, eerr}, {31'h0, e});
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        apb_xfer(1'b0, a, 32'h0000_0000, 4'h0, d, e, lat);
        check_word("read data", exp, d);
        check_word("read error", {31'h0, eerr}, {31'h0, e});
    endtask : reg_rd

    // main sequence
    initial begin
        apb_req = '0;
        bus2_xfer_busy = 1'b0;
        low_power_mode = 1'b0;
        rst_n = 1'b0;
        n_mismatch = 0;
        checked = 0;
        cycles = 0;
        adr = '{HSB_GATE_OFFSET, PB2_GATE_OFFSET};
        msk = '{HSB_GATE_MASK, PB2_GATE_MASK};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(HSB_GATE_OFFSET, GATE_RESET, 1'b0);
        reg_rd(PB2_GATE_OFFSET, GATE_RESET, 1'b0);
        check_gate(exp_gate(32'h0, 32'h0, 1'b0));
        $display("test reset values done");
        for (int i = 0; i < 2; i++) begin
            reg_wr(adr[i], msk[i], 4'hf, 1'b0);
            reg_rd(adr[i], msk[i], 1'b0);
            reg_wr(adr[i], 32'h0000_0000, 4'hf, 1'b0);
            reg_wr(adr[i], msk[i], 4'b0100, 1'b0);
            reg_rd(adr[i], msk[i] & 32'h00ff_0000, 1'b0);
            reg_wr(adr[i], msk[i], 4'b0011, 1'b0);
            reg_rd(adr[i], msk[i] & 32'h00ff_ffff, 1'b0);
            reg_wr(adr[i], 32'h0000_0000, 4'b0001, 1'b0);
            reg_rd(adr[i], msk[i] & 32'h00ff_ff00, 1'b0);
        end
        check_gate(exp_gate(HSB_GATE_MASK & 32'h00ff_ff00, PB2_GATE_MASK & 32'h00ff_ff00, 1'b0));
        $display("test lanes and reserved bits done");
        @(posedge clk);
        low_power_mode <= 1'b1;
        check_gate(exp_gate(HSB_GATE_MASK & 32'h00ff_ff00, PB2_GATE_MASK & 32'h00ff_ff00, 1'b1));
        reg_wr(HSB_GATE_OFFSET, 32'h0000_0010, 4'b0001, 1'b0);
        check_gate(exp_gate(HSB_GATE_MASK & 32'h00ff_ff10, PB2_GATE_MASK & 32'h00ff_ff00, 1'b1));
        reg_wr(HSB_GATE_OFFSET, 32'h0000_0005, 4'b0001, 1'b0);
        check_gate(exp_gate(HSB_GATE_MASK & 32'h00ff_ff05, PB2_GATE_MASK & 32'h00ff_ff00, 1'b1));
        @(posedge clk);
        low_power_mode <= 1'b0;
        $display("test sleep clocks done");
        reg_wr(12'h008, 32'hffff_ffff, 4'hf, 1'b1);
        reg_rd(12'h008, 32'h0000_0000, 1'b1);
        reg_rd(HSB_GATE_OFFSET, HSB_GATE_MASK & 32'h00ff_ff05, 1'b0);
        check_word("unstalled edges within 4", 32'h1, {31'h0, lat <= 4});
        $display("test unmapped access done");
        bus2_xfer_busy <= 1'b1;
        fork
            apb_xfer(1'b0, PB2_GATE_OFFSET, 32'h0000_0000, 4'h0, d, e, lat);
            begin
                repeat (6) @(posedge clk);
                bus2_xfer_busy <= 1'b0;
            end
        join
        check_word("stalled edges above 6", 32'h1, {31'h0, lat >= 7});
        check_word("stalled read data", PB2_GATE_MASK & 32'h00ff_ff00, d);
        $display("test wait states done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(HSB_GATE_OFFSET, GATE_RESET, 1'b0);
        check_gate(exp_gate(32'h0, 32'h0, 1'b0));
        $display("test second reset done");
        stop_test();
    end
endmodule : peripheral_clock_gate_regs_tb
